// File: rtl/gpp_top.sv
// ports d, e and f with peripheral pin sharing behind wishbone
// Summary of operation
// - direction one drives pin, zero floats it
// - reset clears port d direction
// - reset clears port e direction
// - port d read: latch if output, else pin
// - port e read: latch if output, else pin
// - data latches writable at any time
// - input pin write only changes the latch
// - d6 timer a clock, d4 timer b clock
// - selected clock pin ignores its direction bit
// - e7..e5 spi pins while spi enabled
// - e4 slave select unless spi off/master nofault
// - spi slave ignores slave select direction
// - owned e pins: direction only picks readback
// - e3/e2 timer a channels when selected
// - e1 sci receive, e0 sci transmit
// - f1/f0 timer a ch3/2, f5/f4 timer b
// - owned f pins: direction only picks readback
// - f latch kept over reset, f seven pins
// - port f read: latch if output, else pin
// - reset clears port f direction
`timescale 1ns/1ps
module gpp_top
  import gpp_pkg::*;
(
  input  wire logic           clk_sys,              // system clock
  input  wire logic           sys_rst,              // synchronous reset
  // wishbone slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [31:0]    wb_dat_i,
  input  wire logic [3:0]     wb_sel_i,
  output logic                wb_ack_o,
  output logic [31:0]         wb_dat_o,
  // pads
  input  wire logic [D_W-1:0] pin_d_in,
  output logic      [D_W-1:0] pin_d_out,
  output logic      [D_W-1:0] pin_d_oe,
  input  wire logic [E_W-1:0] pin_e_in,
  output logic      [E_W-1:0] pin_e_out,
  output logic      [E_W-1:0] pin_e_oe,
  input  wire logic [F_W-1:0] pin_f_in,
  output logic      [F_W-1:0] pin_f_out,
  output logic      [F_W-1:0] pin_f_oe,
  // sharing controls to peripherals
  output logic      [2:0]     prescaler_select_a,
  output logic      [2:0]     prescaler_select_b,
  output logic                spi_enable_bit,
  output logic                spi_master_bit,
  output logic                mode_fault_enable,
  output logic                sci_enable_bit,
  output logic      [7:0]     edge_level_select_a,
  output logic      [3:0]     edge_level_select_b,
  // timer side
  output logic                timer_a_ext_clock,
  output logic                timer_b_ext_clock,
  input  wire logic [3:0]     timer_a_ch_out,
  input  wire logic [3:0]     timer_a_ch_oe,
  output logic      [3:0]     timer_a_channel_pin,
  input  wire logic [1:0]     timer_b_ch_out,
  input  wire logic [1:0]     timer_b_ch_oe,
  output logic      [1:0]     timer_b_channel_pin,
  // spi side
  input  wire logic           spi_sck_out,
  input  wire logic           spi_mosi_out,
  input  wire logic           spi_miso_out,
  output logic                spi_serial_clock_pin,
  output logic                spi_mosi_pin,
  output logic                spi_miso_pin,
  output logic                spi_ss_n_pin,
  // sci side
  input  wire logic           sci_txd,
  output logic                sci_rxd_pin
);

  gpp_reg_if rb ();                       // bus to core carrier

  logic [D_W-1:0] d_dir;                  // direction d
  logic [E_W-1:0] e_dir;                  // direction e
  logic [F_W-1:0] f_dir;                  // direction f
  logic [D_W-1:0] d_sync;                 // synced pins d
  logic [E_W-1:0] e_sync;                 // synced pins e
  logic [F_W-1:0] f_sync;                 // synced pins f
  logic [D_W-1:0] d_rd;                   // readback d
  logic [E_W-1:0] e_rd;                   // readback e
  logic [F_W-1:0] f_rd;                   // readback f
  logic [D_W-1:0] d_own;                  // peripheral-owned d pins
  logic [D_W-1:0] d_poe;                  // peripheral enables d
  logic [D_W-1:0] d_pout;                 // peripheral data d
  logic [E_W-1:0] e_own;                  // peripheral-owned e pins
  logic [E_W-1:0] e_poe;                  // peripheral enables e
  logic [E_W-1:0] e_pout;                 // peripheral data e
  logic [F_W-1:0] f_own;                  // peripheral-owned f pins
  logic [F_W-1:0] f_poe;                  // peripheral enables f
  logic [F_W-1:0] f_pout;                 // peripheral data f
  logic [3:0]     ta_on;                  // timer a channel active
  logic [1:0]     tb_on;                  // timer b channel active
  logic           ss_used;                // slave select owned by spi
  logic           wr_d_lat;               // write strobes
  logic           wr_e_lat;
  logic           wr_f_lat;
  logic           wr_d_dir;
  logic           wr_e_dir;
  logic           wr_f_dir;

  // bus slave
  gpp_wb_slave u_bus (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .rb       (rb.slave)
  );

  // write decode, latches take writes whatever the direction
  assign wr_d_lat = rb.wr_en & (rb.idx == IDX_DATA_D);
  assign wr_e_lat = rb.wr_en & (rb.idx == IDX_DATA_E);
  assign wr_f_lat = rb.wr_en & (rb.idx == IDX_DATA_F);
  assign wr_d_dir = rb.wr_en & (rb.idx == IDX_DIR_D);
  assign wr_e_dir = rb.wr_en & (rb.idx == IDX_DIR_E);
  assign wr_f_dir = rb.wr_en & (rb.idx == IDX_DIR_F);

  // sharing control register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prescaler_select_a <= 3'h0;
      prescaler_select_b <= 3'h0;
      spi_enable_bit     <= 1'b0;
      spi_master_bit     <= 1'b0;
      mode_fault_enable  <= 1'b0;
      sci_enable_bit     <= 1'b0;
    end else if (rb.wr_en & (rb.idx == IDX_SHARE)) begin
      prescaler_select_a <= rb.wdata[SH_PSA_LSB +: 3];
      prescaler_select_b <= rb.wdata[SH_PSB_LSB +: 3];
      spi_enable_bit     <= rb.wdata[SH_SPE];
      spi_master_bit     <= rb.wdata[SH_MSTR];
      mode_fault_enable  <= rb.wdata[SH_MODF];
      sci_enable_bit     <= rb.wdata[SH_SCI];
    end
  end

  // timer a channel selects
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      edge_level_select_a <= 8'h00;
    end else if (rb.wr_en & (rb.idx == IDX_ELS_A)) begin
      edge_level_select_a <= rb.wdata[7:0];
    end
  end

  // timer b channel selects
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      edge_level_select_b <= 4'h0;
    end else if (rb.wr_en & (rb.idx == IDX_ELS_B)) begin
      edge_level_select_b <= rb.wdata[3:0];
    end
  end

  // channel is on when its edge/level field is non-zero
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ta_on[i] = edge_level_select_a[2*i +: 2] != ELS_OFF;
    end
    for (int j = 0; j < 2; j++) begin
      tb_on[j] = edge_level_select_b[2*j +: 2] != ELS_OFF;
    end
  end

  // port d ownership: clock pins become inputs when picked
  always_comb begin
    d_own = '0;
    d_poe = '0;
    d_pout = '0;
    d_own[D_TA_CLK] = prescaler_select_a == PS_EXT_CLK;
    d_own[D_TB_CLK] = prescaler_select_b == PS_EXT_CLK;
  end

  // slave select owned unless spi off or master without fault check
  assign ss_used = spi_enable_bit & ~(spi_master_bit & ~mode_fault_enable);

  // port e ownership and drive per shared function
  always_comb begin
    e_own = '0;
    e_poe = '0;
    e_pout = '0;
    e_own[E_SCK]   = spi_enable_bit;
    e_poe[E_SCK]   = spi_master_bit;
    e_pout[E_SCK]  = spi_sck_out;
    e_own[E_MOSI]  = spi_enable_bit;
    e_poe[E_MOSI]  = spi_master_bit;
    e_pout[E_MOSI] = spi_mosi_out;
    e_own[E_MISO]  = spi_enable_bit;
    e_poe[E_MISO]  = ~spi_master_bit;
    e_pout[E_MISO] = spi_miso_out;
    e_own[E_SS]    = ss_used;
    e_own[E_TACH1]  = ta_on[1];
    e_poe[E_TACH1]  = timer_a_ch_oe[1];
    e_pout[E_TACH1] = timer_a_ch_out[1];
    e_own[E_TACH0]  = ta_on[0];
    e_poe[E_TACH0]  = timer_a_ch_oe[0];
    e_pout[E_TACH0] = timer_a_ch_out[0];
    e_own[E_RXD]   = sci_enable_bit;
    e_own[E_TXD]   = sci_enable_bit;
    e_poe[E_TXD]   = 1'b1;
    e_pout[E_TXD]  = sci_txd;
  end

  // port f ownership, timer channels only
  always_comb begin
    f_own = '0;
    f_poe = '0;
    f_pout = '0;
    f_own[F_TACH3]  = ta_on[3];
    f_poe[F_TACH3]  = timer_a_ch_oe[3];
    f_pout[F_TACH3] = timer_a_ch_out[3];
    f_own[F_TACH2]  = ta_on[2];
    f_poe[F_TACH2]  = timer_a_ch_oe[2];
    f_pout[F_TACH2] = timer_a_ch_out[2];
    f_own[F_TBCH1]  = tb_on[1];
    f_poe[F_TBCH1]  = timer_b_ch_oe[1];
    f_pout[F_TBCH1] = timer_b_ch_out[1];
    f_own[F_TBCH0]  = tb_on[0];
    f_poe[F_TBCH0]  = timer_b_ch_oe[0];
    f_pout[F_TBCH0] = timer_b_ch_out[0];
  end

  // port d, direction cleared on reset
  gpp_port #(.W(D_W)) u_port_d (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .wr_latch (wr_d_lat),
    .wr_dir   (wr_d_dir),
    .wdata    (rb.wdata[D_W-1:0]),
    .own      (d_own),
    .p_oe     (d_poe),
    .p_out    (d_pout),
    .pin_in   (pin_d_in),
    .dir_q    (d_dir),
    .pin_sync (d_sync),
    .rd_val   (d_rd),
    .pin_out  (pin_d_out),
    .pin_oe   (pin_d_oe)
  );

  // port e, owned pins keep direction for readback only
  gpp_port #(.W(E_W)) u_port_e (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .wr_latch (wr_e_lat),
    .wr_dir   (wr_e_dir),
    .wdata    (rb.wdata[E_W-1:0]),
    .own      (e_own),
    .p_oe     (e_poe),
    .p_out    (e_pout),
    .pin_in   (pin_e_in),
    .dir_q    (e_dir),
    .pin_sync (e_sync),
    .rd_val   (e_rd),
    .pin_out  (pin_e_out),
    .pin_oe   (pin_e_oe)
  );

  // port f, seven pins, latch kept over reset
  gpp_port #(.W(F_W)) u_port_f (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .wr_latch (wr_f_lat),
    .wr_dir   (wr_f_dir),
    .wdata    (rb.wdata[F_W-1:0]),
    .own      (f_own),
    .p_oe     (f_poe),
    .p_out    (f_pout),
    .pin_in   (pin_f_in),
    .dir_q    (f_dir),
    .pin_sync (f_sync),
    .rd_val   (f_rd),
    .pin_out  (pin_f_out),
    .pin_oe   (pin_f_oe)
  );

  // register readback, low byte only except share control bits 11:8, rest zero
  always_comb begin
    rb.rdata = 32'h0000_0000;
    unique case (rb.idx)
      IDX_DATA_D: rb.rdata[D_W-1:0] = d_rd;
      IDX_DATA_E: rb.rdata[E_W-1:0] = e_rd;
      IDX_DATA_F: rb.rdata[F_W-1:0] = f_rd;
      IDX_DIR_D:  rb.rdata[D_W-1:0] = d_dir;
      IDX_DIR_E:  rb.rdata[E_W-1:0] = e_dir;
      IDX_DIR_F:  rb.rdata[F_W-1:0] = f_dir;
      IDX_SHARE: begin
        rb.rdata[SH_PSA_LSB +: 3] = prescaler_select_a;
        rb.rdata[SH_PSB_LSB +: 3] = prescaler_select_b;
        rb.rdata[SH_SPE]  = spi_enable_bit;
        rb.rdata[SH_MSTR] = spi_master_bit;
        rb.rdata[SH_MODF] = mode_fault_enable;
        rb.rdata[SH_SCI]  = sci_enable_bit;
      end
      IDX_ELS_A:  rb.rdata[7:0] = edge_level_select_a;
      IDX_ELS_B:  rb.rdata[3:0] = edge_level_select_b;
      default:    rb.rdata = 32'h0000_0000;            // unmapped reads zero
    endcase
  end

  // synced pin levels handed to the peripherals, one flop past sync
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_a_ext_clock    <= 1'b0;
      timer_b_ext_clock    <= 1'b0;
      timer_a_channel_pin  <= 4'h0;
      timer_b_channel_pin  <= 2'h0;
      spi_serial_clock_pin <= 1'b0;
      spi_mosi_pin         <= 1'b0;
      spi_miso_pin         <= 1'b0;
      spi_ss_n_pin         <= 1'b1;
      sci_rxd_pin          <= 1'b1;
    end else begin
      timer_a_ext_clock    <= d_sync[D_TA_CLK];
      timer_b_ext_clock    <= d_sync[D_TB_CLK];
      timer_a_channel_pin  <= {f_sync[F_TACH3], f_sync[F_TACH2], e_sync[E_TACH1], e_sync[E_TACH0]};
      timer_b_channel_pin  <= {f_sync[F_TBCH1], f_sync[F_TBCH0]};
      spi_serial_clock_pin <= e_sync[E_SCK];
      spi_mosi_pin         <= e_sync[E_MOSI];
      spi_miso_pin         <= e_sync[E_MISO];
      spi_ss_n_pin         <= e_sync[E_SS] | ~ss_used;   // idle high when not owned
      sci_rxd_pin          <= e_sync[E_RXD];
    end
  end

endmodule : gpp_top

// File: rtl/gpp_pkg.sv
// constants shared by the port d/e/f sharing logic
package gpp_pkg;
  localparam int          D_W          = 8;     // port d pins
  localparam int          E_W          = 8;     // port e pins
  localparam int          F_W          = 7;     // port f pins
  localparam int          IDX_W        = 6;     // register index width
  // register indices, byte address is four times the index
  localparam logic [5:0]  IDX_DATA_D   = 6'h03;
  localparam logic [5:0]  IDX_DATA_E   = 6'h08;
  localparam logic [5:0]  IDX_DATA_F   = 6'h09;
  localparam logic [5:0]  IDX_DIR_D    = 6'h10;
  localparam logic [5:0]  IDX_DIR_E    = 6'h11;
  localparam logic [5:0]  IDX_DIR_F    = 6'h12;
  localparam logic [5:0]  IDX_SHARE    = 6'h14;
  localparam logic [5:0]  IDX_ELS_A    = 6'h15;
  localparam logic [5:0]  IDX_ELS_B    = 6'h16;
  // share control field positions
  localparam int          SH_PSA_LSB   = 0;     // timer a prescaler select [2:0]
  localparam int          SH_PSB_LSB   = 3;     // timer b prescaler select [5:3]
  localparam int          SH_SPE       = 8;
  localparam int          SH_MSTR      = 9;
  localparam int          SH_MODF      = 10;
  localparam int          SH_SCI       = 11;
  localparam logic [2:0]  PS_EXT_CLK   = 3'h7;  // prescaler code picking the pin clock
  localparam logic [1:0]  ELS_OFF      = 2'h0;  // channel released to the port
  // pin positions of shared functions
  localparam int          D_TA_CLK     = 6;
  localparam int          D_TB_CLK     = 4;
  localparam int          E_SCK        = 7;
  localparam int          E_MOSI       = 6;
  localparam int          E_MISO       = 5;
  localparam int          E_SS         = 4;
  localparam int          E_TACH1      = 3;
  localparam int          E_TACH0      = 2;
  localparam int          E_RXD        = 1;
  localparam int          E_TXD        = 0;
  localparam int          F_TACH3      = 1;
  localparam int          F_TACH2      = 0;
  localparam int          F_TBCH1      = 5;
  localparam int          F_TBCH0      = 4;
endpackage : gpp_pkg

// File: rtl/gpp_reg_if.sv
// register access carrier between bus slave and port core
`timescale 1ns/1ps
interface gpp_reg_if;
  logic        wr_en;   // one-cycle write strobe
  logic [5:0]  idx;     // register index
  logic [31:0] wdata;   // write word, share control bits in 11:8 and 5:0
  logic [31:0] rdata;   // read word for idx
  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport core  (input wr_en, input idx, input wdata, output rdata);
endinterface : gpp_reg_if

// File: rtl/gpp_wb_slave.sv
// classic wishbone slave, one wait state, registered ack and data
`timescale 1ns/1ps
module gpp_wb_slave
  import gpp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  gpp_reg_if.slave         rb
);
  logic req;  // live request not yet answered

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rb.idx   = wb_adr_i[7:2];
  assign rb.wdata = wb_dat_i;
  // write lands at the edge where ack rises
  assign rb.wr_en = req & wb_we_i & wb_sel_i[0];

  // ack for one cycle, dropped the cycle after
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read word captured with the ack, unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_we_i) begin
      wb_dat_o <= rb.rdata;
    end
  end
endmodule : gpp_wb_slave

// File: rtl/gpp_port.sv
// one gpio port: latch, direction, pin sync, read mux, pad drive
`timescale 1ns/1ps
module gpp_port #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         wr_latch,
  input  wire logic         wr_dir,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] own,
  input  wire logic [W-1:0] p_oe,
  input  wire logic [W-1:0] p_out,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] dir_q,
  output logic      [W-1:0] pin_sync,
  output logic      [W-1:0] rd_val,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);
  logic [W-1:0] latch_reg;  // data latch, kept over reset
  logic [W-1:0] meta_reg;   // first sync stage

  // latch always writable, never touched by reset
  always_ff @(posedge clk_sys) begin
    if (wr_latch) begin
      latch_reg <= wdata;
    end
  end

  // direction cleared by reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_q <= '0;
    end else if (wr_dir) begin
      dir_q <= wdata;
    end
  end

  // two-stage pin synchroniser
  always_ff @(posedge clk_sys) begin
    meta_reg <= pin_in;
    pin_sync <= meta_reg;
  end

  // latch where output, pin where input
  assign rd_val = (dir_q & latch_reg) | (~dir_q & pin_sync);

  // pad drive: peripheral owns or direction decides
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      pin_oe  <= (own & p_oe) | (~own & dir_q);
      pin_out <= (own & p_out) | (~own & latch_reg);
    end
  end
endmodule : gpp_port

// File: verification/gpp_pin_model.sv
// pad and peripheral model beyond ports d, e and f
`timescale 1ns/1ps
module gpp_pin_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] ext_d,           // level on released d pads
  input  wire logic [7:0] ext_e,           // level on released e pads
  input  wire logic [6:0] ext_f,           // level on released f pads
  input  wire logic [7:0] pin_d_out,
  input  wire logic [7:0] pin_d_oe,
  input  wire logic [7:0] pin_e_out,
  input  wire logic [7:0] pin_e_oe,
  input  wire logic [6:0] pin_f_out,
  input  wire logic [6:0] pin_f_oe,
  output logic      [7:0] pin_d_in,
  output logic      [7:0] pin_e_in,
  output logic      [6:0] pin_f_in,
  output logic      [3:0] timer_a_ch_out,
  output logic      [3:0] timer_a_ch_oe,
  output logic      [1:0] timer_b_ch_out,
  output logic      [1:0] timer_b_ch_oe,
  output logic            spi_sck_out,
  output logic            spi_mosi_out,
  output logic            spi_miso_out,
  output logic            sci_txd
);
  logic [7:0] act_cnt = 8'h00;             // activity pattern of peripherals
  // peripheral outputs follow a free-running counter so tracking is visible
  always_ff @(posedge clk_sys) begin
    act_cnt <= act_cnt + 8'h01;
  end
  // a driven pad reads back its own level, else the outside level
  assign pin_d_in = (pin_d_oe & pin_d_out) | (~pin_d_oe & ext_d);
  assign pin_e_in = (pin_e_oe & pin_e_out) | (~pin_e_oe & ext_e);
  assign pin_f_in = (pin_f_oe & pin_f_out) | (~pin_f_oe & ext_f);
  assign timer_a_ch_out = act_cnt[7:4];
  assign timer_a_ch_oe  = 4'hF;
  assign timer_b_ch_out = act_cnt[5:4];
  assign timer_b_ch_oe  = 2'h3;
  assign {spi_sck_out, spi_mosi_out, spi_miso_out, sci_txd} = act_cnt[3:0];
endmodule : gpp_pin_model

// File: verification/gpp_top_properties.sv
// port-level checks of the d/e/f pin sharing block
`timescale 1ns/1ps
module gpp_top_properties
  import gpp_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [7:0] pin_d_in,
  input wire logic [7:0] pin_d_oe,
  input wire logic [7:0] pin_e_out,
  input wire logic [7:0] pin_e_oe,
  input wire logic [6:0] pin_f_oe,
  input wire logic [2:0] prescaler_select_a,
  input wire logic       spi_enable_bit,
  input wire logic       spi_master_bit,
  input wire logic       sci_enable_bit,
  input wire logic [7:0] edge_level_select_a,
  input wire logic       timer_a_ext_clock,
  input wire logic [3:0] timer_a_ch_out,
  input wire logic [3:0] timer_a_ch_oe,
  input wire logic       sci_txd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [2:0] run_cnt;                     // cycles since reset, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_cnt <= 3'h0;
    end else if (run_cnt != 3'h7) begin
      run_cnt <= run_cnt + 3'h1;
    end
  end
  AST_RST_FLOAT: assert property ($fell(sys_rst) |-> pin_d_oe == 8'h00 && pin_e_oe == 8'h00 && pin_f_oe == 7'h00)
    else $error("pads driven right after reset");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_CLK_PIN_IN: assert property (prescaler_select_a == PS_EXT_CLK && $past(prescaler_select_a) == PS_EXT_CLK
    |-> !pin_d_oe[D_TA_CLK])
    else $error("timer clock pin driven");
  AST_CLK_FOLLOW: assert property (run_cnt == 3'h7 |-> timer_a_ext_clock == $past(pin_d_in[D_TA_CLK], 3))
    else $error("timer clock does not follow its pad");
  AST_SPI_MASTER: assert property (spi_enable_bit && spi_master_bit && $past(spi_enable_bit) && $past(spi_master_bit)
    |-> pin_e_oe[E_SCK] && pin_e_oe[E_MOSI] && !pin_e_oe[E_MISO])
    else $error("spi master pad directions wrong");
  AST_SCI_TX: assert property (sci_enable_bit && $past(sci_enable_bit)
    |-> pin_e_oe[E_TXD] && !pin_e_oe[E_RXD] && pin_e_out[E_TXD] == $past(sci_txd))
    else $error("sci pads not handed over");
  AST_TA_CH0: assert property (edge_level_select_a[1:0] != ELS_OFF && $past(edge_level_select_a[1:0]) != ELS_OFF
    |-> pin_e_out[E_TACH0] == $past(timer_a_ch_out[0]) && pin_e_oe[E_TACH0] == $past(timer_a_ch_oe[0]))
    else $error("timer channel pad not handed over");
endmodule : gpp_top_properties
bind gpp_top gpp_top_properties u_props (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pin_d_in, .pin_d_oe,
  .pin_e_out, .pin_e_oe, .pin_f_oe, .prescaler_select_a, .spi_enable_bit, .spi_master_bit, .sci_enable_bit,
  .edge_level_select_a, .timer_a_ext_clock, .timer_a_ch_out, .timer_a_ch_oe, .sci_txd);

// File: verification/test_gpio_ports_d_e_f_with_pin_sharing.sv
// self-checking bench for ports d, e and f with pin sharing
`timescale 1ns/1ps
module test_gpio_ports_d_e_f_with_pin_sharing
  import gpp_pkg::*;
;
  logic        clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, pin_d_in, pin_d_out, pin_d_oe, pin_e_in, pin_e_out, pin_e_oe;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, timer_a_ch_out, timer_a_ch_oe;
  logic [6:0]  pin_f_in, pin_f_out, pin_f_oe;
  logic [1:0]  timer_b_ch_out, timer_b_ch_oe;
  logic        timer_a_ext_clock, sci_rxd_pin, spi_sck_out, spi_mosi_out, spi_miso_out, sci_txd;
  logic [7:0]  ext [3];                    // outside level of released pads
  logic [7:0]  lat [3];                    // latch contents last written
  logic [5:0]  dat_i [3] = '{IDX_DATA_D, IDX_DATA_E, IDX_DATA_F};
  logic [5:0]  dir_i [3] = '{IDX_DIR_D, IDX_DIR_E, IDX_DIR_F};
  logic [31:0] sh_t [5] = '{32'h100, 32'h300, 32'h700, 32'h800, 32'h0}; // slave, master, fault, sci, off
  logic [7:0]  oe_t [5] = '{8'h2F, 8'hDF, 8'hCF, 8'hFD, 8'hFF};
  integer      seed = 32'h5AFC4E72;
  int          n_fail, checks_done;
  gpp_top dut (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o,
    .wb_dat_o, .pin_d_in, .pin_d_out, .pin_d_oe, .pin_e_in, .pin_e_out, .pin_e_oe, .pin_f_in, .pin_f_out,
    .pin_f_oe, .prescaler_select_a(), .prescaler_select_b(), .spi_enable_bit(), .spi_master_bit(),
    .mode_fault_enable(), .sci_enable_bit(), .edge_level_select_a(), .edge_level_select_b(), .timer_a_ext_clock,
    .timer_b_ext_clock(), .timer_a_ch_out, .timer_a_ch_oe, .timer_a_channel_pin(), .timer_b_ch_out, .timer_b_ch_oe,
    .timer_b_channel_pin(), .spi_sck_out, .spi_mosi_out, .spi_miso_out, .spi_serial_clock_pin(), .spi_mosi_pin(),
    .spi_miso_pin(), .spi_ss_n_pin(), .sci_txd, .sci_rxd_pin);
  gpp_pin_model u_pads (.clk_sys, .ext_d(ext[0]), .ext_e(ext[1]), .ext_f(ext[2][6:0]), .pin_d_out, .pin_d_oe,
    .pin_e_out, .pin_e_oe, .pin_f_out, .pin_f_oe, .pin_d_in, .pin_e_in, .pin_f_in, .timer_a_ch_out,
    .timer_a_ch_oe, .timer_b_ch_out, .timer_b_ch_oe, .spi_sck_out, .spi_mosi_out, .spi_miso_out, .sci_txd);
  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] ad(input logic [5:0] i);
    return {i, 2'b00};
  endfunction : ad
  // read value: latch where output, pad where input
  function automatic logic [31:0] exp_rd(input logic [7:0] l, input logic [7:0] d, input logic [7:0] x);
    return {24'h0, (l & d) | (x & ~d)};
  endfunction : exp_rd
  function automatic logic [7:0] oe_of(input int p);
    return p == 0 ? pin_d_oe : p == 1 ? pin_e_oe : {1'b0, pin_f_oe};
  endfunction : oe_of
  function automatic logic [7:0] out_of(input int p);
    return p == 0 ? pin_d_out : p == 1 ? pin_e_out : {1'b0, pin_f_out};
  endfunction : out_of
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one classic wishbone cycle, held until ack
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50) n_fail++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, e);
  endtask : rd_chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
  initial begin : main
    logic [7:0] l, d, x, m;
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    ext = '{8'h00, 8'h00, 8'h00};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    check({pin_d_oe, pin_e_oe, pin_f_oe}, 23'h0);
    rd_chk(ad(IDX_DIR_D), 32'h0);
    rd_chk(ad(IDX_DIR_E), 32'h0);
    wr(8'hFC, 32'hFF);
    rd_chk(8'hFC, 32'h0);
    // random latch, direction and pad levels on each port
    for (int i = 0; i < 18; i++) begin
      m = (i % 3 == 2) ? 8'h7F : 8'hFF;
      l = $random(seed);
      d = $random(seed);
      x = $random(seed);
      ext[i % 3] <= x;
      wr(ad(dat_i[i % 3]), {24'h0, l});
      wr(ad(dir_i[i % 3]), {24'h0, d});
      repeat (4) @(posedge clk_sys);
      check(oe_of(i % 3), d & m);
      check(out_of(i % 3) & d & m, l & d & m);
      rd_chk(ad(dat_i[i % 3]), exp_rd(l, d, x) & m);
      wr(ad(dat_i[i % 3]), {24'h0, ~l});
      lat[i % 3] = ~l & m;
      rd_chk(ad(dat_i[i % 3]), exp_rd(~l, d, x) & m);
    end
    wr(ad(IDX_DIR_D), 32'hFF);
    wr(ad(IDX_SHARE), {26'h0, PS_EXT_CLK, PS_EXT_CLK});
    ext[0] <= 8'h40;
    repeat (5) @(posedge clk_sys);
    check(pin_d_oe, 8'hAF);
    check(timer_a_ext_clock, 1'b1);
    wr(ad(IDX_DIR_E), 32'hFF);
    for (int k = 0; k < 5; k++) begin
      wr(ad(IDX_SHARE), sh_t[k]);
      repeat (4) @(posedge clk_sys);
      check(pin_e_oe, oe_t[k]);
      rd_chk(ad(IDX_DATA_E), {24'h0, lat[1]});
      if (k == 3) check(sci_rxd_pin, ext[1][E_RXD]);
    end
    wr(ad(IDX_DIR_E), 32'h0);
    wr(ad(IDX_DIR_F), 32'h0);
    wr(ad(IDX_ELS_A), 32'hFF);
    wr(ad(IDX_ELS_B), 32'h0F);
    repeat (4) @(posedge clk_sys);
    check(pin_e_oe, 8'h0C);
    check(pin_f_oe, 7'h33);
    wr(ad(IDX_DIR_F), 32'h7F);
    rd_chk(ad(IDX_DATA_F), {24'h0, lat[2]});
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(ad(IDX_DIR_F), 32'h0);
    wr(ad(IDX_DIR_F), 32'h7F);
    rd_chk(ad(IDX_DATA_F), {24'h0, lat[2]});
    give_verdict();
  end
endmodule : test_gpio_ports_d_e_f_with_pin_sharing
